// ===== src/blpc_pkg.sv
// Package for the dark-offset and sensor format configuration block.
// Assumes a single 100 MHz clock domain; all ports of blpc_config are plain wires.
package blpc_pkg;

  // Offset target selector encodings
  typedef enum logic [1:0] {
    pre_correction_digital,
    post_correction_digital,
    analog_taps_target
  } blpc_target_e;

  // Sample depth encodings
  typedef enum logic [1:0] {
    depth_eight,
    depth_nine,
    depth_ten
  } blpc_depth_e;

  // Sensor shape encodings
  typedef enum logic {
    shape_four_three,
    shape_square
  } blpc_shape_e;

  localparam int          OFS_W             = 12;
  localparam int          DEPTH_N           = 3;
  localparam logic [11:0] PRE_SPAN          = 12'h0FF;
  localparam logic [11:0] POST_MAX          = 12'h401;
  localparam logic [11:0] ANALOG_MAX        = 12'h401;
  localparam logic [11:0] OFS_RST           = 12'h000;
  localparam logic [1:0]  TARGET_RST        = 2'h0;
  localparam logic [1:0]  DEPTH_RST         = 2'h0;
  localparam logic        SHAPE_RST         = 1'h0;
  localparam logic [11:0] WIDTH_43          = 12'h800;
  localparam logic [11:0] HEIGHT_43         = 12'h600;
  localparam logic [11:0] WIDTH_11          = 12'h600;
  localparam logic [11:0] HEIGHT_11         = 12'h600;
  localparam logic [2:0]  AOI_COUNT_RST     = 3'h1;
  localparam logic [2:0]  AOI_SEL_RST       = 3'h0;
  localparam logic [11:0] ZERO_REF_DEFAULT  = 12'h020;

endpackage : blpc_pkg

// ===== src/blpc_offset_if.sv
// Interface carrying the per-depth analog offset store port.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface blpc_offset_if;
  import blpc_pkg::*;
  logic [1:0]       wr_idx;
  logic             wr_en;
  logic [OFS_W-1:0] wr_data;
  logic [1:0]       rd_idx;
  logic [OFS_W-1:0] rd_data;
  modport ctrl (output wr_idx, output wr_en, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_idx, input wr_en, input wr_data, input rd_idx, output rd_data);
endinterface : blpc_offset_if
`default_nettype wire

// ===== src/blpc_depth_mem.sv
// Small memory holding one analog dark offset per sample depth.
// Assumes synchronous access; read data leaves through a register.
`timescale 1ns/10ps
`default_nettype none
module blpc_depth_mem
  import blpc_pkg::*;
#(
  parameter int DEPTH = DEPTH_N
) (
  input  wire logic  mclk_in,
  input  wire logic  rst_in,
  blpc_offset_if.store port_if
);
  logic [OFS_W-1:0] mem_q [DEPTH];
  logic [OFS_W-1:0] mem_d [DEPTH];
  logic [OFS_W-1:0] rd_q;
  logic [OFS_W-1:0] rd_d;

  // Next contents and registered read; write-through so a recall sees fresh data
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
      if (port_if.wr_en && port_if.wr_idx == 2'(i)) begin
        mem_d[i] = port_if.wr_data;
      end
    end
    rd_d = OFS_RST;
    if (int'(port_if.rd_idx) < DEPTH) begin
      rd_d = mem_d[port_if.rd_idx];
    end
  end

  // Storage registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= OFS_RST;
      end
      rd_q <= OFS_RST;
    end else begin
      mem_q <= mem_d;
      rd_q  <= rd_d;
    end
  end

  assign port_if.rd_data = rd_q;
endmodule // blpc_depth_mem
`default_nettype wire

// ===== src/blpc_config.sv
// Dark-offset and sensor format configuration block.
// Assumes host control arrives on plain same-clock ports, one write strobe per access;
// the trigger gating level comes from a pin and is synchronised here.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - A two-bit selector picks which offset later value accesses reach.
// - Pre-correction target drives a global offset ahead of flat field correction.
// - Post-correction target drives a background subtraction after flat field correction.
// - Analog target drives one offset shared by all analog taps.
// - Offset value is writable, but writes are ignored while trigger gating is on.
// - Post-correction range is zero up to 1025.
// - Offsets in converter units; one analog offset kept per sample depth.
// - Sample depth selects 8, 9 or 10 bit digitizing.
// - Shape select picks a 4:3 or 1:1 active area.
// - Any shape change recomputes geometry and area-of-interest values.
module blpc_config
  import blpc_pkg::*;
#(
  parameter logic [OFS_W-1:0] ZERO_REF = ZERO_REF_DEFAULT
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic             trigger_gating_in,
  input  wire logic             target_wr_in,
  input  wire logic [1:0]       target_data_in,
  input  wire logic             offset_wr_in,
  input  wire logic [OFS_W-1:0] offset_data_in,
  input  wire logic             depth_wr_in,
  input  wire logic [1:0]       depth_data_in,
  input  wire logic             shape_wr_in,
  input  wire logic             shape_data_in,
  output logic [1:0]            offset_target_select_out,
  output logic [OFS_W-1:0]      dark_offset_value_out,
  output logic                  offset_write_reject_out,
  output logic [OFS_W-1:0]      pre_correction_offset_out,
  output logic [OFS_W-1:0]      post_correction_offset_out,
  output logic [OFS_W-1:0]      analog_offset_out,
  output logic [1:0]            depth_out,
  output logic [3:0]            depth_bits_out,
  output logic                  sensor_shape_select_out,
  output logic                  geometry_update_out,
  output logic [OFS_W-1:0]      sensor_width_out,
  output logic [OFS_W-1:0]      sensor_height_out,
  output logic [OFS_W-1:0]      image_offset_x_out,
  output logic [OFS_W-1:0]      image_offset_y_out,
  output logic [OFS_W-1:0]      image_width_out,
  output logic [OFS_W-1:0]      image_height_out,
  output logic [2:0]            aoi_count_out,
  output logic [2:0]            aoi_select_out,
  output logic [OFS_W-1:0]      aoi_offset_x_out,
  output logic [OFS_W-1:0]      aoi_offset_y_out,
  output logic [OFS_W-1:0]      aoi_width_out,
  output logic [OFS_W-1:0]      aoi_height_out
);

  // Bit count for each depth code; used only for the depth_bits_out output
  function automatic logic [3:0] depth_bits(input logic [1:0] code);
    unique case (code)
      2'h0:    depth_bits = 4'h8;
      2'h1:    depth_bits = 4'h9;
      2'h2:    depth_bits = 4'hA;
      default: depth_bits = 4'h8;
    endcase
  endfunction

  // Legal encodings only; the fourth code of each two-bit field is refused
  function automatic logic code_legal(input logic [1:0] code);
    code_legal = (code != 2'h3);
  endfunction

  // Trigger gating pin: three flops, change taken once stages two and three agree
  logic [2:0] gate_sync_q;
  logic [2:0] gate_sync_d;
  logic       gate_q;
  logic       gate_d;

  always_comb begin
    gate_sync_d = {gate_sync_q[1:0], trigger_gating_in};
    gate_d      = gate_q;
    if (gate_sync_q[1] == gate_sync_q[2]) begin
      gate_d = gate_sync_q[2];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gate_sync_q <= 3'h0;
      gate_q      <= 1'h0;
    end else begin
      gate_sync_q <= gate_sync_d;
      gate_q      <= gate_d;
    end
  end

  // Per-depth analog offset store
  blpc_offset_if store_if ();

  blpc_depth_mem #(
    .DEPTH (DEPTH_N)
  ) u_depth_mem (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .port_if (store_if.store)
  );

  // Configuration state
  logic [1:0]       target_q,  target_d;
  logic [1:0]       depth_q,   depth_d;
  logic             shape_q,   shape_d;
  logic [OFS_W-1:0] pre_q,     pre_d;
  logic [OFS_W-1:0] post_q,    post_d;
  logic             reject_q,  reject_d;
  logic             update_q,  update_d;
  logic             in_range;
  logic             ofs_take;

  // Range check for the currently selected target; the pre-correction value is
  // two's complement, so its window spans -ZERO_REF up to PRE_SPAN-ZERO_REF
  always_comb begin
    logic signed [OFS_W:0] sval;
    logic signed [OFS_W:0] lo;
    logic signed [OFS_W:0] hi;
    sval     = $signed({offset_data_in[OFS_W-1], offset_data_in});
    lo       = -$signed({1'b0, ZERO_REF});
    hi       = $signed({1'b0, PRE_SPAN}) - $signed({1'b0, ZERO_REF});
    in_range = 1'b0;
    unique case (target_q)
      2'h0:    in_range = (sval >= lo) && (sval <= hi);
      2'h1:    in_range = offset_data_in <= POST_MAX;
      2'h2:    in_range = offset_data_in <= ANALOG_MAX;
      default: in_range = 1'b0;
    endcase
    ofs_take = offset_wr_in && !gate_q && in_range;
  end

  // Next configuration values
  always_comb begin
    target_d = target_q;
    depth_d  = depth_q;
    shape_d  = shape_q;
    pre_d    = pre_q;
    post_d   = post_q;
    reject_d = offset_wr_in && !gate_q && !in_range;
    update_d = 1'b0;
    if (target_wr_in && code_legal(target_data_in)) begin
      target_d = target_data_in;
    end
    if (depth_wr_in && code_legal(depth_data_in)) begin
      depth_d = depth_data_in;
    end
    if (shape_wr_in) begin
      shape_d  = shape_data_in;
      update_d = (shape_data_in != shape_q);
    end
    if (ofs_take && target_q == 2'h0) begin
      pre_d = offset_data_in;
    end
    if (ofs_take && target_q == 2'h1) begin
      post_d = offset_data_in;
    end
  end

  // Store port: write the analog offset under the current depth, read back
  // the entry of the depth about to be in force so a depth change recalls it
  assign store_if.wr_en   = ofs_take && (target_q == 2'h2);
  assign store_if.wr_idx  = depth_q;
  assign store_if.wr_data = offset_data_in;
  assign store_if.rd_idx  = depth_d;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      target_q <= TARGET_RST;
      depth_q  <= DEPTH_RST;
      shape_q  <= SHAPE_RST;
      pre_q    <= OFS_RST;
      post_q   <= OFS_RST;
      reject_q <= 1'b0;
      update_q <= 1'b0;
    end else begin
      target_q <= target_d;
      depth_q  <= depth_d;
      shape_q  <= shape_d;
      pre_q    <= pre_d;
      post_q   <= post_d;
      reject_q <= reject_d;
      update_q <= update_d;
    end
  end

  // Geometry derived from the shape; recomputed on every shape change, which also
  // resets the area-of-interest set to one full-frame region
  logic [OFS_W-1:0] width_q,  width_d;
  logic [OFS_W-1:0] height_q, height_d;
  logic [2:0]       aoi_cnt_q, aoi_cnt_d;
  logic [2:0]       aoi_sel_q, aoi_sel_d;

  always_comb begin
    width_d   = width_q;
    height_d  = height_q;
    aoi_cnt_d = aoi_cnt_q;
    aoi_sel_d = aoi_sel_q;
    if (shape_wr_in && shape_data_in != shape_q) begin
      width_d   = shape_data_in ? WIDTH_11 : WIDTH_43;
      height_d  = shape_data_in ? HEIGHT_11 : HEIGHT_43;
      aoi_cnt_d = AOI_COUNT_RST;
      aoi_sel_d = AOI_SEL_RST;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      width_q   <= WIDTH_43;
      height_q  <= HEIGHT_43;
      aoi_cnt_q <= AOI_COUNT_RST;
      aoi_sel_q <= AOI_SEL_RST;
    end else begin
      width_q   <= width_d;
      height_q  <= height_d;
      aoi_cnt_q <= aoi_cnt_d;
      aoi_sel_q <= aoi_sel_d;
    end
  end

  // Window origins; every shape change puts them back on the sensor's corner.
  // Held in flops so that these ports leave a register like every other output
  logic [OFS_W-1:0] img_x_q, img_x_d;
  logic [OFS_W-1:0] img_y_q, img_y_d;
  logic [OFS_W-1:0] aoi_x_q, aoi_x_d;
  logic [OFS_W-1:0] aoi_y_q, aoi_y_d;

  always_comb begin
    img_x_d = img_x_q;
    img_y_d = img_y_q;
    aoi_x_d = aoi_x_q;
    aoi_y_d = aoi_y_q;
    if (shape_wr_in && shape_data_in != shape_q) begin
      img_x_d = OFS_RST;
      img_y_d = OFS_RST;
      aoi_x_d = OFS_RST;
      aoi_y_d = OFS_RST;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      img_x_q <= OFS_RST;
      img_y_q <= OFS_RST;
      aoi_x_q <= OFS_RST;
      aoi_y_q <= OFS_RST;
    end else begin
      img_x_q <= img_x_d;
      img_y_q <= img_y_d;
      aoi_x_q <= aoi_x_d;
      aoi_y_q <= aoi_y_d;
    end
  end

  // Readback of the value that the selector points at
  logic [OFS_W-1:0] readback_q, readback_d;
  logic [3:0]       bits_q,     bits_d;

  always_comb begin
    unique case (target_q)
      2'h0:    readback_d = pre_q;
      2'h1:    readback_d = post_q;
      2'h2:    readback_d = store_if.rd_data;
      default: readback_d = OFS_RST;
    endcase
    bits_d = depth_bits(depth_q);
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      readback_q <= OFS_RST;
      bits_q     <= 4'h8;
    end else begin
      readback_q <= readback_d;
      bits_q     <= bits_d;
    end
  end

  // Outputs straight from flops; the analog offset comes from the store's read register
  assign offset_target_select_out   = target_q;
  assign dark_offset_value_out      = readback_q;
  assign offset_write_reject_out    = reject_q;
  assign pre_correction_offset_out  = pre_q;
  assign post_correction_offset_out = post_q;
  assign analog_offset_out          = store_if.rd_data;
  assign depth_out                  = depth_q;
  assign depth_bits_out             = bits_q;
  assign sensor_shape_select_out    = shape_q;
  assign geometry_update_out        = update_q;
  assign sensor_width_out           = width_q;
  assign sensor_height_out          = height_q;
  assign image_offset_x_out         = img_x_q;
  assign image_offset_y_out         = img_y_q;
  assign image_width_out            = width_q;
  assign image_height_out           = height_q;
  assign aoi_count_out              = aoi_cnt_q;
  assign aoi_select_out             = aoi_sel_q;
  assign aoi_offset_x_out           = aoi_x_q;
  assign aoi_offset_y_out           = aoi_y_q;
  assign aoi_width_out              = width_q;
  assign aoi_height_out             = height_q;

endmodule // blpc_config
`default_nettype wire

// ===== testbench/blpc_config_assertions.sv
// Concurrent checks for the dark-offset and sensor format block.
// Assumes it is bound to blpc_config and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module blpc_config_assertions
  import blpc_pkg::*;
(
  input wire logic             mclk_in,
  input wire logic             rst_in,
  input wire logic             trigger_gating_in,
  input wire logic [1:0]       offset_target_select_out,
  input wire logic             offset_write_reject_out,
  input wire logic [OFS_W-1:0] pre_correction_offset_out,
  input wire logic [OFS_W-1:0] post_correction_offset_out,
  input wire logic [1:0]       depth_out,
  input wire logic [3:0]       depth_bits_out,
  input wire logic             sensor_shape_select_out,
  input wire logic             geometry_update_out,
  input wire logic [OFS_W-1:0] sensor_width_out,
  input wire logic [OFS_W-1:0] sensor_height_out,
  input wire logic [OFS_W-1:0] image_offset_x_out,
  input wire logic [2:0]       aoi_count_out
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Selector only ever holds legal codes
  AST_TARGET_LEGAL: assert property (offset_target_select_out != 2'h3)
    else $error("selector holds the unused code");
  // Bit count trails the depth by a cycle, so wait for it to settle
  AST_DEPTH_BITS: assert property ($stable(depth_out) [*2] |-> depth_bits_out == 4'h8 + 4'(depth_out))
    else $error("depth bit count disagrees with depth");
  AST_GEOM_SHAPE: assert property ($stable(sensor_shape_select_out) [*2] |->
    sensor_width_out == (sensor_shape_select_out ? WIDTH_11 : WIDTH_43) &&
    sensor_height_out == (sensor_shape_select_out ? HEIGHT_11 : HEIGHT_43))
    else $error("sensor geometry disagrees with shape");
  AST_GEOM_PULSE: assert property ($changed(sensor_shape_select_out) |-> ##[0:1] geometry_update_out)
    else $error("shape change without geometry update");
  AST_FIXED_AOI: assert property (image_offset_x_out == 12'h000 && aoi_count_out == 3'h1)
    else $error("area of interest left off full frame");
  // Six cycles of gating cover the three-flop synchroniser
  AST_GATED_HOLD: assert property (trigger_gating_in [*6] |=>
    $stable(pre_correction_offset_out) && $stable(post_correction_offset_out))
    else $error("offset changed while gating on");
  AST_REJECT_KEEP: assert property (offset_write_reject_out |->
    $stable(pre_correction_offset_out) && $stable(post_correction_offset_out))
    else $error("refused write changed an offset");
  AST_POST_RANGE: assert property (post_correction_offset_out <= POST_MAX)
    else $error("post offset above its range");

  // Main scenarios reached
  COV_REJECT: cover property (offset_write_reject_out);
  COV_SHAPE: cover property (geometry_update_out && sensor_shape_select_out);
  COV_DEPTH: cover property (depth_bits_out == 4'hA);
endmodule // blpc_config_assertions

bind blpc_config blpc_config_assertions u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .trigger_gating_in(trigger_gating_in), .offset_target_select_out(offset_target_select_out),
  .offset_write_reject_out(offset_write_reject_out), .pre_correction_offset_out(pre_correction_offset_out),
  .post_correction_offset_out(post_correction_offset_out), .depth_out(depth_out),
  .depth_bits_out(depth_bits_out), .sensor_shape_select_out(sensor_shape_select_out),
  .geometry_update_out(geometry_update_out), .sensor_width_out(sensor_width_out),
  .sensor_height_out(sensor_height_out), .image_offset_x_out(image_offset_x_out),
  .aoi_count_out(aoi_count_out));
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the dark-offset and sensor format block.
// Assumes blpc_config with its default zero reference; checker comes by bind.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import blpc_pkg::*;
  logic             mclk_in = 1'b0, rst_in = 1'b1, trigger_gating_in = 1'b0, shape_data_in = 1'b0;
  logic             target_wr_in = 1'b0, offset_wr_in = 1'b0, depth_wr_in = 1'b0, shape_wr_in = 1'b0;
  logic [1:0]       target_data_in = 2'h0, depth_data_in = 2'h0, offset_target_select_out, depth_out;
  logic [OFS_W-1:0] offset_data_in = 12'h000;
  logic [3:0]       depth_bits_out;
  logic [2:0]       aoi_count_out, aoi_select_out;
  logic             offset_write_reject_out, sensor_shape_select_out, geometry_update_out, rej, upd;
  logic [OFS_W-1:0] dark_offset_value_out, pre_correction_offset_out, post_correction_offset_out, analog_offset_out;
  logic [OFS_W-1:0] sensor_width_out, sensor_height_out, image_offset_x_out, image_offset_y_out, image_width_out;
  logic [OFS_W-1:0] image_height_out, aoi_offset_x_out, aoi_offset_y_out, aoi_width_out, aoi_height_out;
  integer           seed = 59;
  int               err_total = 0, checks = 0;
  logic [1:0]       m_tgt = 2'h0, m_dep = 2'h0;
  logic             m_shp = 1'b0;
  logic [OFS_W-1:0] m_pre = 12'h000, m_post = 12'h000, m_ana [3] = '{12'h000, 12'h000, 12'h000};
  // Kind in the top bits (0 selector, 1 offset, 2 depth, 3 shape, 4 gating), value below
  logic [14:0]      corner [$] = '{15'h0002, 15'h2000, 15'h1007, 15'h2001, 15'h1401, 15'h2002, 15'h1402,
    15'h2001, 15'h0000, 15'h1FE0, 15'h1FDF, 15'h10DF, 15'h10E0, 15'h0001, 15'h1401, 15'h1402, 15'h0003,
    15'h2003, 15'h3001, 15'h3001, 15'h4001, 15'h1005, 15'h0000, 15'h1010, 15'h4000, 15'h3000};

  blpc_config DUT (.mclk_in, .rst_in, .trigger_gating_in, .target_wr_in, .target_data_in, .offset_wr_in,
    .offset_data_in, .depth_wr_in, .depth_data_in, .shape_wr_in, .shape_data_in, .offset_target_select_out,
    .dark_offset_value_out, .offset_write_reject_out, .pre_correction_offset_out, .post_correction_offset_out,
    .analog_offset_out, .depth_out, .depth_bits_out, .sensor_shape_select_out, .geometry_update_out,
    .sensor_width_out, .sensor_height_out, .image_offset_x_out, .image_offset_y_out, .image_width_out,
    .image_height_out, .aoi_count_out, .aoi_select_out, .aoi_offset_x_out, .aoi_offset_y_out, .aoi_width_out,
    .aoi_height_out);

  // 100 MHz clock
  always #5 mclk_in = ~mclk_in;

  task automatic check(input logic [OFS_W-1:0] got, input logic [OFS_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One access, then a settle gap long enough for the gating synchroniser
  task automatic op(input logic [14:0] c);
    logic [OFS_W-1:0] d, w, h;
    logic             er, eu, ok;
    int               s;
    d = c[11:0];
    s = int'($signed(d));
    er = 1'b0;
    eu = 1'b0;
    ok = (m_tgt == 2'h0) ? (s >= -int'(ZERO_REF_DEFAULT) && s <= 255 - int'(ZERO_REF_DEFAULT))
                         : (d <= ((m_tgt == 2'h1) ? POST_MAX : ANALOG_MAX));
    @(posedge mclk_in);
    target_data_in <= d[1:0];
    depth_data_in <= d[1:0];
    shape_data_in <= d[0];
    offset_data_in <= d;
    target_wr_in <= (c[14:12] == 3'h0);
    offset_wr_in <= (c[14:12] == 3'h1);
    depth_wr_in <= (c[14:12] == 3'h2);
    shape_wr_in <= (c[14:12] == 3'h3);
    if (c[14:12] == 3'h4) trigger_gating_in <= d[0];
    @(posedge mclk_in);
    {target_wr_in, offset_wr_in, depth_wr_in, shape_wr_in} <= 4'h0;
    rej = 1'b0;
    upd = 1'b0;
    repeat (5) begin
      @(posedge mclk_in);
      rej = rej | offset_write_reject_out;
      upd = upd | geometry_update_out;
    end
    // Reference model of what the access should have done
    case (c[14:12])
      3'h0: if (d[1:0] != 2'h3) m_tgt = d[1:0];
      3'h1: if (!trigger_gating_in) begin
        er = !ok;
        if (ok && m_tgt == 2'h0) m_pre = d;
        if (ok && m_tgt == 2'h1) m_post = d;
        if (ok && m_tgt == 2'h2) m_ana[m_dep] = d;
      end
      3'h2: if (d[1:0] != 2'h3) m_dep = d[1:0];
      3'h3: begin
        eu = d[0] ^ m_shp;
        m_shp = d[0];
      end
      default: ;
    endcase
    w = m_shp ? WIDTH_11 : WIDTH_43;
    h = m_shp ? HEIGHT_11 : HEIGHT_43;
    check(12'(offset_target_select_out), 12'(m_tgt));
    check(dark_offset_value_out, (m_tgt == 2'h0) ? m_pre : (m_tgt == 2'h1) ? m_post : m_ana[m_dep]);
    check(pre_correction_offset_out, m_pre);
    check(post_correction_offset_out, m_post);
    check(analog_offset_out, m_ana[m_dep]);
    check(12'(depth_bits_out), 12'h008 + 12'(m_dep));
    check(sensor_width_out, w);
    check(image_width_out, w);
    check(aoi_width_out, w);
    check(12'({upd, rej}), 12'({eu, er}));
    check(12'(depth_out), 12'(m_dep));
    check(12'(sensor_shape_select_out), 12'(m_shp));
    check(sensor_height_out, h);
    check(image_height_out, h);
    check(aoi_height_out, h);
    check(image_offset_x_out | image_offset_y_out | aoi_offset_x_out | aoi_offset_y_out, 12'h000);
    check(12'({aoi_count_out, aoi_select_out}), 12'({AOI_COUNT_RST, AOI_SEL_RST}));
  endtask

  // Corner cases first, then random accesses with offsets kept near the legal ranges
  initial begin
    logic [2:0]       k;
    logic [OFS_W-1:0] v;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    foreach (corner[i]) op(corner[i]);
    repeat (300) begin
      k = 3'($unsigned($random(seed)) % 5);
      v = 12'($random(seed));
      if (v[10]) v = {{4{v[11]}}, v[7:0]};
      op({k, v});
    end
    complete_run();
  end

  // Roughly 330 accesses of 7 cycles each; far beyond that means a hang
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
